// ==== logic/vrc_cfg.svh ====
// Purpose: timing constants of the recorder control sequencer
// Assumes: 50 MHz core clock; figures are given at an 8 kHz sample rate
// Notes: definitions only
`ifndef VRC_CFG_SVH
`define VRC_CFG_SVH

`define VRC_CLK_HZ 50000000
`define VRC_CYC_PER_US (`VRC_CLK_HZ / 1000000)
`define VRC_CYC(us) ((us) * `VRC_CYC_PER_US)
`define VRC_FSAMP_REF_HZ 8000

// least pulse width on begin, halt, pause
`define VRC_T_PULSE_US 40
// address control at start of recording or playback and at end of recording
`define VRC_T_AD_US 1000
// oscillator settling after begin in idle power-down
`define VRC_T_ANA_US 32000
// output ramp at start and end of playback in idle power-down
`define VRC_T_AOR_US 64000
`define VRC_T_AOF_US 256000
// indicator fall to power-down
`define VRC_T_MS_US 70
// host busy times
`define VRC_T_BR_US 125
`define VRC_T_B1_US 16
`define VRC_T_BAW_US 270
`define VRC_T_BAD_US 50

`endif

// ==== logic/vrc_pkg.sv ====
// Purpose: types of the recorder control sequencer
// Assumes: nothing
// Notes: states are Gray coded in declaration order, which the record/playback path does not follow step by step
package vrc_pkg;

  typedef enum logic [3:0] {
    VRC_IDLE       = 4'h0,
    VRC_OSC_WAIT   = 4'h1,
    VRC_ADDR_START = 4'h3,
    VRC_RAMP_UP    = 4'h2,
    VRC_ACTIVE     = 4'h6,
    VRC_ADDR_END   = 4'h7,
    VRC_RAMP_DOWN  = 4'h5,
    VRC_PD_ENTER   = 4'h4,
    VRC_VOICE_WAIT = 4'hC,
    VRC_PAUSED     = 4'hE
  } vrc_state_t;

  typedef enum logic [2:0] {
    VRC_CMD_ONE      = 3'h0,
    VRC_CMD_TWO      = 3'h1,
    VRC_CMD_DATA     = 3'h2,
    VRC_CMD_PTR_WR   = 3'h3,
    VRC_CMD_PTR_ADDR = 3'h4,
    VRC_CMD_PTR_RD   = 3'h5
  } vrc_cmd_t;

endpackage : vrc_pkg

// ==== logic/vrc_ctrl.sv ====
// Purpose: control sequencer of a voice recorder/player, stand-alone and host paths
// Assumes: core_clk 50 MHz; pins are asynchronous; cmd_* and the memory flags are on core_clk
// Notes: all latencies scale with 8 kHz / FSAMP_HZ
//
// How it works
// - latencies scale with sampling period; pulses >= 40 us
// - 1 ms address control before sample data
// - 1 ms address control storing recording end
// - halt leaves voice standby within 500 us
// - pause stops recording or playback within 250 us
// - begin while paused resumes within 500 us
// - power-down mode: 32 ms oscillator settle after begin
// - power-down mode: halt in recording, indicator falls fast
// - power-down mode: halt in playback, falls within 260 ms
// - power-down mode: 64 ms ramp at playback start
// - power-down mode: 256 ms ramp at playback end
// - power-down entered 70 us after indicator falls (playback) or address control ends (recording)
// - power-down mode: halt while paused ends operation
// - no power-down: indicator rises within 1 ms
// - no power-down: indicator falls within 1 ms of halt
// - no power-down: voice standby within 1 ms
// - no power-down: halt while paused ends within 1 ms
// - host busy 125 us after reset plus settling
// - busy at most 16 us per nibble command
// - pointer write busy 270 us, address nibble 50 us
`include "vrc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module vrc_ctrl import vrc_pkg::*; #(
  parameter int unsigned FSAMP_HZ = `VRC_FSAMP_REF_HZ,
  parameter int unsigned AD_CYC = `VRC_CYC(`VRC_T_AD_US),
  parameter int unsigned ANA_CYC = `VRC_CYC(`VRC_T_ANA_US),
  parameter int unsigned AOR_CYC = `VRC_CYC(`VRC_T_AOR_US),
  parameter int unsigned AOF_CYC = `VRC_CYC(`VRC_T_AOF_US),
  parameter int unsigned BR_CYC = `VRC_CYC(`VRC_T_BR_US),
  parameter int unsigned BAW_CYC = `VRC_CYC(`VRC_T_BAW_US),
  parameter int unsigned OSC_SETTLE_CYC = 0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // stand-alone pins
  input wire logic begin_pulse_n_in,
  input wire logic halt_pulse_n_in,
  input wire logic pause_pulse_n_in,
  input wire logic phrase_select_bit0,
  input wire logic phrase_select_bit1,
  input wire logic phrase_select_bit2,
  input wire logic direction_select,
  input wire logic idle_powerdown_select,
  input wire logic voice_trigger_en,
  // from the analog and memory side
  input wire logic voice_detect,
  input wire logic msg_end,
  // host port
  input wire logic host_mode,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_kind,
  output logic cmd_taken,
  output logic busy,
  // status
  output logic activity_indicator,
  output logic addr_ctrl,
  output logic sample_move,
  output logic voice_standby,
  output logic paused,
  output logic ramp_active,
  output logic powerdown,
  output logic rec_mode,
  output logic [2:0] phrase_latched
);

  // ---------------------------------------------------------------
  // scaled cycle counts
  // ---------------------------------------------------------------
  function automatic int unsigned vrc_scale(input longint unsigned base, input bit up);
    longint unsigned num;
    longint unsigned q;
    num = base * `VRC_FSAMP_REF_HZ;
    q = up ? (num + FSAMP_HZ - 1) / FSAMP_HZ : num / FSAMP_HZ;
    vrc_scale = (q == 0) ? 1 : 32'(q);
  endfunction : vrc_scale

  localparam int unsigned K_PULSE = vrc_scale(`VRC_CYC(`VRC_T_PULSE_US), 1'b1);
  localparam int unsigned K_AD = vrc_scale(AD_CYC, 1'b0);
  localparam int unsigned K_ANA = vrc_scale(ANA_CYC, 1'b0);
  localparam int unsigned K_AOR = vrc_scale(AOR_CYC, 1'b0);
  localparam int unsigned K_AOF = vrc_scale(AOF_CYC, 1'b0);
  localparam int unsigned K_MS = vrc_scale(`VRC_CYC(`VRC_T_MS_US), 1'b0);
  localparam int unsigned K_BR = vrc_scale(BR_CYC, 1'b0);
  localparam int unsigned K_B1 = vrc_scale(`VRC_CYC(`VRC_T_B1_US), 1'b0);
  localparam int unsigned K_BAW = vrc_scale(BAW_CYC, 1'b0);
  localparam int unsigned K_BAD = vrc_scale(`VRC_CYC(`VRC_T_BAD_US), 1'b0);

  if (FSAMP_HZ < 1000 || FSAMP_HZ > 64000) begin : g_bad_fsamp
    $error("vrc_ctrl: FSAMP_HZ out of range");
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // pulse inputs: sync, width filter, one event per pulse
  // ---------------------------------------------------------------
  logic [2:0] pulse_raw_n;
  logic [2:0] pulse_ev;
  logic host_sel;
  assign pulse_raw_n = {pause_pulse_n_in, halt_pulse_n_in, begin_pulse_n_in};

  for (genvar i = 0; i < 3; i++) begin : g_pulse
    logic s1_r;
    logic s2_r;
    logic [31:0] wid_r;
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        s1_r <= 1'b1;
        s2_r <= 1'b1;
        wid_r <= 32'h0000_0000;
      end else begin
        s1_r <= pulse_raw_n[i];
        s2_r <= s1_r;
        // saturate so a long press fires once only
        if (s2_r) wid_r <= 32'h0000_0000;
        else if (wid_r != K_PULSE) wid_r <= wid_r + 32'h0000_0001;
      end
    end
    assign pulse_ev[i] = !s2_r && (wid_r == K_PULSE - 1) && !host_sel;
  end

  logic begin_ev;
  logic halt_ev;
  logic pause_ev;
  assign begin_ev = pulse_ev[0];
  assign halt_ev = pulse_ev[1];
  assign pause_ev = pulse_ev[2];

  // ---------------------------------------------------------------
  // level pins: two-flop synchronisers
  // ---------------------------------------------------------------
  logic [6:0] lvl_s1_r;
  logic [6:0] lvl_s2_r;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lvl_s1_r <= 7'h3F;
      lvl_s2_r <= 7'h3F;
    end else begin
      lvl_s1_r <= {host_mode, voice_trigger_en, idle_powerdown_select, direction_select,
                   phrase_select_bit2, phrase_select_bit1, phrase_select_bit0};
      lvl_s2_r <= lvl_s1_r;
    end
  end

  logic pd_sel;
  logic vox_en;
  logic dir_rec;
  assign pd_sel = !lvl_s2_r[4];
  assign vox_en = lvl_s2_r[5];
  assign dir_rec = lvl_s2_r[3];
  assign host_sel = lvl_s2_r[6];

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  vrc_state_t state_r;
  vrc_state_t state_nxt;
  logic [31:0] tmr_r;
  logic [31:0] tmr_nxt;
  logic [31:0] age_r;
  logic rec_r;
  logic [2:0] phrase_r;
  logic pd_r;
  logic pd_nxt;
  logic tmr_done;
  logic tracking;
  vrc_state_t start_tgt;
  vrc_state_t stop_tgt;

  assign tmr_done = (tmr_r == 32'h0000_0000);
  assign tracking = (state_r == VRC_IDLE) || (state_r == VRC_OSC_WAIT) ||
                    (state_r == VRC_VOICE_WAIT);
  assign start_tgt = (dir_rec && vox_en) ? VRC_VOICE_WAIT : VRC_ADDR_START;
  assign stop_tgt = rec_r ? VRC_ADDR_END : (pd_sel ? VRC_RAMP_DOWN : VRC_IDLE);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      VRC_IDLE: if (begin_ev) state_nxt = pd_sel ? VRC_OSC_WAIT : start_tgt;
      VRC_OSC_WAIT: if (tmr_done) state_nxt = start_tgt;
      VRC_VOICE_WAIT: begin
        if (halt_ev) state_nxt = VRC_IDLE;
        else if (voice_detect) state_nxt = VRC_ADDR_START;
      end
      VRC_ADDR_START: begin
        if (tmr_done) state_nxt = (!rec_r && pd_sel) ? VRC_RAMP_UP : VRC_ACTIVE;
      end
      VRC_RAMP_UP: begin
        if (halt_ev) state_nxt = stop_tgt;
        else if (tmr_done) state_nxt = VRC_ACTIVE;
      end
      VRC_ACTIVE: begin
        if (halt_ev || msg_end) state_nxt = stop_tgt;
        else if (pause_ev) state_nxt = VRC_PAUSED;
      end
      VRC_PAUSED: begin
        if (halt_ev) state_nxt = stop_tgt;
        else if (begin_ev) state_nxt = VRC_ACTIVE;
      end
      VRC_ADDR_END: if (tmr_done) state_nxt = pd_sel ? VRC_PD_ENTER : VRC_IDLE;
      VRC_RAMP_DOWN: if (tmr_done) state_nxt = VRC_PD_ENTER;
      VRC_PD_ENTER: if (tmr_done) state_nxt = VRC_IDLE;
      default: state_nxt = VRC_IDLE;
    endcase
  end

  // timer reloads on every state change, one less than the interval
  always_comb begin
    tmr_nxt = tmr_done ? tmr_r : tmr_r - 32'h0000_0001;
    if (state_nxt != state_r) begin
      case (state_nxt)
        VRC_OSC_WAIT: tmr_nxt = K_ANA - 1;
        VRC_ADDR_START: tmr_nxt = K_AD - 1;
        VRC_ADDR_END: tmr_nxt = K_AD - 1;
        VRC_RAMP_UP: tmr_nxt = K_AOR - 1;
        VRC_RAMP_DOWN: tmr_nxt = K_AOF - 1;
        VRC_PD_ENTER: tmr_nxt = K_MS - 1;
        default: tmr_nxt = 32'h0000_0000;
      endcase
    end
  end

  // power-down follows the tail of an operation; a begin wakes the part, but a begin during VRC_PD_ENTER is lost
  assign pd_nxt = (state_r == VRC_PD_ENTER && tmr_done) ? 1'b1 :
                  (begin_ev ? 1'b0 : pd_r);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= VRC_IDLE;
      tmr_r <= 32'h0000_0000;
      age_r <= 32'h0000_0000;
      pd_r <= 1'b0;
      rec_r <= 1'b0;
      phrase_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      age_r <= (state_nxt != state_r) ? 32'h0000_0000 :
               ((&age_r) ? age_r : age_r + 32'h0000_0001);
      pd_r <= pd_nxt;
      // selection freezes once the indicator rises; the pins may move later
      if (tracking) begin
        rec_r <= dir_rec;
        phrase_r <= lvl_s2_r[2:0];
      end
    end
  end

  assign activity_indicator = (state_r == VRC_ADDR_START) || (state_r == VRC_RAMP_UP) ||
                              (state_r == VRC_ACTIVE) || (state_r == VRC_PAUSED) ||
                              (state_r == VRC_RAMP_DOWN);
  assign addr_ctrl = (state_r == VRC_ADDR_START) || (state_r == VRC_ADDR_END);
  assign sample_move = (state_r == VRC_ACTIVE);
  assign voice_standby = (state_r == VRC_VOICE_WAIT);
  assign paused = (state_r == VRC_PAUSED);
  assign ramp_active = (state_r == VRC_RAMP_UP) || (state_r == VRC_RAMP_DOWN);
  assign powerdown = pd_r;
  assign rec_mode = rec_r;
  assign phrase_latched = phrase_r;

  // ---------------------------------------------------------------
  // host busy
  // ---------------------------------------------------------------
  logic [31:0] busy_r;
  logic [31:0] busy_load;
  assign busy = (busy_r != 32'h0000_0000);
  // commands while busy are dropped; the host must poll busy first
  assign cmd_taken = host_sel && cmd_valid && !busy;
  assign busy_load = (cmd_kind == VRC_CMD_PTR_WR) ? K_BAW :
                     (cmd_kind == VRC_CMD_PTR_ADDR) ? K_BAD : K_B1;

  always_ff @(posedge core_clk) begin
    if (!rst_n) busy_r <= K_BR + OSC_SETTLE_CYC;
    else if (cmd_taken) busy_r <= busy_load;
    else if (busy) busy_r <= busy_r - 32'h0000_0001;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence halt_in_run;
    (state_r == VRC_ACTIVE) && halt_ev && !msg_end;
  endsequence

  sequence leave_state(vrc_state_t s);
    (state_r == s) && (state_nxt != s);
  endsequence

  pause_stop_a: assert property ((state_r == VRC_ACTIVE) && pause_ev && !halt_ev && !msg_end
    |=> paused && !sample_move) else $error("pause not taken");
  resume_go_a: assert property ((state_r == VRC_PAUSED) && begin_ev && !halt_ev
    |=> sample_move) else $error("resume not taken");
  vstby_exit_a: assert property ((state_r == VRC_VOICE_WAIT) && halt_ev
    |=> !voice_standby && !activity_indicator) else $error("standby kept");
  rec_halt_a: assert property (halt_in_run ##0 rec_r
    |=> !activity_indicator ##0 addr_ctrl) else $error("record halt late");
  addr_len_a: assert property (leave_state(VRC_ADDR_START)
    |-> age_r == K_AD - 1) else $error("address control length");
  ramp_len_a: assert property (leave_state(VRC_RAMP_DOWN)
    |-> age_r == K_AOF - 1 ##1 (state_r == VRC_PD_ENTER) && !activity_indicator)
    else $error("ramp down length");
  pd_enter_a: assert property (leave_state(VRC_PD_ENTER)
    |-> age_r == K_MS - 1 ##1 powerdown) else $error("power-down timing");
  osc_wait_a: assert property (leave_state(VRC_OSC_WAIT) ##0 !halt_ev
    |-> age_r == K_ANA - 1) else $error("oscillator wait length");
  busy_cmd_a: assert property (cmd_taken && (cmd_kind == VRC_CMD_ONE)
    |=> busy && (busy_r == K_B1)) else $error("nibble busy length");
  busy_ptr_a: assert property (cmd_taken && (cmd_kind == VRC_CMD_PTR_WR)
    |=> busy_r == K_BAW) else $error("pointer busy length");
  busy_step_a: assert property (busy |=> busy_r == $past(busy_r) - 32'h0000_0001)
    else $error("busy count step");
  fast_rise_a: assert property ((state_r == VRC_IDLE) && begin_ev && !pd_sel
    && !(dir_rec && vox_en) |=> activity_indicator) else $error("indicator rise late");

endmodule : vrc_ctrl

`default_nettype wire

// ==== verif/vrc_buttons.sv ====
// Purpose: push-button side of the recorder control pins
// Assumes: pins rest high through pull-ups while no button is held
// Notes: a press is held whole cycles, never shorter than asked
`timescale 1ns/1ps
`default_nettype none

module vrc_buttons (
  // clock
  input wire logic core_clk,
  // active-low pulse pins
  output logic begin_pulse_n_in,
  output logic halt_pulse_n_in,
  output logic pause_pulse_n_in
);
  initial begin
    begin_pulse_n_in = 1'b1;
    halt_pulse_n_in = 1'b1;
    pause_pulse_n_in = 1'b1;
  end

  // which: 0 begin, 1 halt, 2 pause; one press gives one low period
  task automatic press(input int which, input int len);
    @(posedge core_clk);
    case (which)
      0: begin_pulse_n_in <= 1'b0;
      1: halt_pulse_n_in <= 1'b0;
      default: pause_pulse_n_in <= 1'b0;
    endcase
    repeat (len) @(posedge core_clk);
    begin_pulse_n_in <= 1'b1;
    halt_pulse_n_in <= 1'b1;
    pause_pulse_n_in <= 1'b1;
  endtask : press
endmodule : vrc_buttons

`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench of the recorder control sequencer
// Assumes: shortened counts, 8 kHz sample rate
// Notes: latencies are counted in core_clk cycles
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int KP = 2000;
  localparam int AD = 50;
  localparam int ANA = 100;
  localparam int AOR = 80;
  localparam int AOF = 120;
  // host hold-off after a pointer read, before its first nibble is read
  localparam int WAR = 13500;
  typedef struct {int lo; int hi;} vrc_note_t;
  logic core_clk, rst_n, dir, pd_sel, vtrig, hmode, cmd_valid;
  logic [2:0] ph, cmd_kind, phl;
  logic bgn_n, hlt_n, pse_n, cmd_taken, busy, act, addr, move;
  logic vstby, psd, ramp, pdn, recm, vdet, mend;
  int n_fail, comparisons;
  vrc_note_t notes[$];
  vrc_note_t nt;
  logic [31:0] seen[$];
  logic [31:0] g;
  event res_ev;

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  vrc_buttons btn (.core_clk(core_clk), .begin_pulse_n_in(bgn_n),
    .halt_pulse_n_in(hlt_n), .pause_pulse_n_in(pse_n));

  vrc_ctrl #(.AD_CYC(AD), .ANA_CYC(ANA), .AOR_CYC(AOR), .AOF_CYC(AOF),
    .BR_CYC(30), .BAW_CYC(60), .OSC_SETTLE_CYC(0)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .begin_pulse_n_in(bgn_n),
    .halt_pulse_n_in(hlt_n), .pause_pulse_n_in(pse_n),
    .phrase_select_bit0(ph[0]), .phrase_select_bit1(ph[1]),
    .phrase_select_bit2(ph[2]), .direction_select(dir),
    .idle_powerdown_select(pd_sel), .voice_trigger_en(vtrig),
    .voice_detect(vdet), .msg_end(mend), .host_mode(hmode),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_taken(cmd_taken),
    .busy(busy), .activity_indicator(act), .addr_ctrl(addr),
    .sample_move(move), .voice_standby(vstby), .paused(psd),
    .ramp_active(ramp), .powerdown(pdn), .rec_mode(recm), .phrase_latched(phl));

  // ----------------------------------------
  // checking
  // ----------------------------------------
  initial forever begin
    @(res_ev);
    while (seen.size() > 0) begin
      nt = notes.pop_front();
      g = seen.pop_front();
      comparisons++;
      if ((^g === 1'bx) || int'(g) < nt.lo || int'(g) > nt.hi) begin
        n_fail++;
        $display("wrong value at %0t: got %0d, want %0d..%0d", $time, g, nt.lo, nt.hi);
      end
    end
  end

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  function automatic logic pick(input int s);
    case (s)
      0: pick = busy;
      1: pick = act;
      2: pick = addr;
      3: pick = move;
      4: pick = vstby;
      5: pick = psd;
      6: pick = ramp;
      default: pick = pdn;
    endcase
  endfunction : pick

  task automatic note(input int lo, input int hi, input logic [31:0] v);
    notes.push_back('{lo, hi});
    seen.push_back(v);
    -> res_ev;
  endtask : note

  task automatic meas(input int s, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (pick(s) !== v) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > 20000) begin
        n_fail++;
        $display("wrong value at %0t: wait on output %0d ran out", $time, s);
        final_report();
      end
    end
    note(lo, hi, n);
  endtask : meas

  // pulse lengths vary so the filter is seen at several widths
  task automatic step(input int b, input int s, input logic v, input int lo, input int hi);
    wait fork;
    #1;
    fork
      btn.press(b, KP + 20 + $urandom_range(0, 40));
    join_none
    meas(s, v, lo, hi);
  endtask : step

  task automatic setio(input logic d, input logic p, input logic v);
    wait fork;
    @(posedge core_clk);
    hmode <= 1'b0;
    dir <= d;
    pd_sel <= p;
    vtrig <= v;
    ph <= 3'($urandom_range(0, 7));
    #1;
  endtask : setio

  // taken, then refused while busy, then busy length
  task automatic cmd(input logic [2:0] k, input int lim);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    #1;
    note(1, 1, {31'h0000_0000, cmd_taken});
    @(posedge core_clk);
    #1;
    note(0, 0, {31'h0000_0000, cmd_taken});
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    #1;
    meas(0, 1'b0, lim - 1, lim - 1);
  endtask : cmd

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    {dir, vtrig, cmd_valid, cmd_kind, ph, vdet, mend} = '0;
    pd_sel = 1'b1;
    hmode = 1'b1;
    void'($urandom(32'h0000_83be));
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    meas(0, 1'b0, 1, 32);
    for (int k = 0; k < 6; k++) begin
      cmd(3'(k), (k == 3) ? 60 : (k == 4) ? 2500 : 800);
    end
    // the pointer read came last; its short busy is over long before this
    repeat (WAR - 800) @(posedge core_clk);
    #1;
    note(0, 0, {31'h0000_0000, busy});
    setio(1'b0, 1'b1, 1'b0);
    step(0, 1, 1'b1, 0, KP + 10);
    meas(3, 1'b1, AD - 1, AD + 1);
    note(0, 0, {28'h0000_000, recm, phl ^ ph});
    step(2, 5, 1'b1, 0, KP + 10);
    step(0, 3, 1'b1, 0, KP + 10);
    step(2, 5, 1'b1, 0, KP + 10);
    step(1, 1, 1'b0, 0, KP + 10);
    setio(1'b1, 1'b1, 1'b0);
    step(0, 3, 1'b1, 0, KP + AD + 10);
    note(1, 1, {31'h0000_0000, recm});
    step(1, 1, 1'b0, 0, KP + 10);
    meas(2, 1'b0, AD - 1, AD + 1);
    setio(1'b1, 1'b1, 1'b1);
    step(0, 4, 1'b1, 0, KP + 10);
    step(1, 4, 1'b0, 0, KP + 10);
    step(0, 4, 1'b1, 0, KP + 10);
    @(posedge core_clk);
    vdet <= 1'b1;
    #1;
    meas(1, 1'b1, 1, 1);
    meas(3, 1'b1, AD - 1, AD + 1);
    @(posedge core_clk);
    vdet <= 1'b0;
    mend <= 1'b1;
    @(posedge core_clk);
    mend <= 1'b0;
    #1;
    note(1, 1, {30'h0000_0000, act, addr});
    meas(2, 1'b0, AD - 1, AD + 1);
    setio(1'b0, 1'b0, 1'b0);
    step(0, 2, 1'b1, KP + ANA, KP + ANA + 10);
    meas(6, 1'b1, AD - 1, AD + 1);
    meas(3, 1'b1, AOR - 1, AOR + 1);
    step(1, 6, 1'b1, 0, KP + 10);
    meas(1, 1'b0, AOF - 1, AOF + 1);
    meas(7, 1'b1, 3499, 3501);
    wait fork;
    #1;
    final_report();
  end
endmodule : tb_top

`default_nettype wire
